/* File: common/adc_monitor_pkg.sv */
package adc_monitor_pkg;

  // Channel counts and widths
  localparam int NUM_CH   = 7;
  localparam int NUM_LIM  = 6;
  localparam int DATA_W   = 16;
  localparam int VAL_W    = 15;
  localparam int CODE_W   = 8;
  localparam int CHAN_W   = 3;
  localparam int FAULT_W  = 2 * NUM_LIM;

  // Channel indices
  localparam logic [2:0] CH_CORE     = 3'h0;
  localparam logic [2:0] CH_INPUT12  = 3'h1;
  localparam logic [2:0] CH_C0_PRI   = 3'h2;
  localparam logic [2:0] CH_C0_SEC   = 3'h3;
  localparam logic [2:0] CH_C1_PRI   = 3'h4;
  localparam logic [2:0] CH_C1_SEC   = 3'h5;
  localparam logic [2:0] CH_TEMP     = 3'h6;

  // Command codes
  localparam logic [7:0] CMD_MONITOR_SELECT     = 8'h00;
  localparam logic [7:0] CMD_TRACKING_ALIGNMENT = 8'h01;
  localparam logic [7:0] CMD_TEST_CONTROL       = 8'h02;
  localparam logic [7:0] CMD_FAULT_ENABLE       = 8'h03;
  localparam logic [7:0] CMD_HELD_FAULT         = 8'h04;
  localparam logic [7:0] CMD_RESULT_BASE        = 8'h10;
  localparam logic [7:0] CMD_HIGH_BASE          = 8'h20;
  localparam logic [7:0] CMD_LOW_BASE           = 8'h28;

  // Field positions
  localparam int FRESH_BIT      = 15;
  localparam int SYNC_BIT       = 0;
  localparam int TEST_WRITE_BIT = 0;
  localparam int BEGIN_RAMP_BIT = 1;
  localparam int UV_FIELD_LSB   = NUM_LIM;

  // Limit codes that switch a comparison off, and reset values
  localparam logic [14:0] HIGH_DISABLE   = 15'h3FFF;
  localparam logic [14:0] LOW_DISABLE    = 15'h4000;
  localparam logic [14:0] RESULT_RESET   = 15'h0000;
  localparam logic [6:0]  MONITOR_RESET  = 7'h00;
  localparam logic [11:0] FAULT_EN_RESET = 12'h000;
  localparam int          ALIGN_CYCLES_DEFAULT = 8;

  // Register command from the serial front end
  typedef struct packed {
    logic        write;
    logic [7:0]  code;
    logic [15:0] wdata;
  } cmd_t;

  // Converted word handed across the link boundary
  typedef struct packed {
    logic [2:0]  chan;
    logic [14:0] value;
  } sample_t;

endpackage

/* File: verilog/adc_monitor_limit_regs.sv */
`timescale 1ns/1ns
// Contract
// - Seven monitor enables; set means convert continuously
// - Writing alignment one aligns tracking channels
// - Alignment bit reads status; upper bits zero
// - Unaligned device returns alignment bit low
// - Result is signed 15 bits, bit 14 sign
// - Codes 4000 negative, 0000 zero, 3FFF positive
// - Results writable only in result-write test mode
// - Fresh flag set on update, cleared by read
// - Over fault when result exceeds high limit
// - High limit 3FFF disables over detection
// - Under fault compares result with low limit
// - Low limit 4000 disables under detection
// - Test mode blocks converter result updates
// - Enabled instantaneous faults latch held bits
// - Ramp start bit begins tracking, reads pending
module adc_monitor_limit_regs
  import adc_monitor_pkg::*;
#(
  parameter int ALIGN_CYCLES = ALIGN_CYCLES_DEFAULT
)(
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                cmd_valid_i,
  input  wire cmd_t                cmd_i,
  output logic                     rsp_valid_o,
  output logic [DATA_W-1:0]        rsp_data_o,
  input  wire logic                ramp_done_i,
  output logic                     ramp_start_o,
  output logic [NUM_LIM-1:0]       ov_fault_o,
  output logic [NUM_LIM-1:0]       uv_fault_o,
  output logic [FAULT_W-1:0]       held_fault_o,
  input  wire logic                adc_clk_i,
  input  wire logic                sample_valid_i,
  input  wire logic [VAL_W-1:0]    sample_value_i,
  output logic [CHAN_W-1:0]        adc_select_o,
  output logic                     adc_run_o
);

  localparam int CNT_W = $clog2(ALIGN_CYCLES + 1);

  // Elaboration check on parameters
  if (ALIGN_CYCLES < 1) begin : g_bad_align
    $error("ALIGN_CYCLES must be at least one");
  end

  // ---------------- system clock state ----------------
  logic [NUM_CH-1:0]           mon_q,     mon_d;
  logic                        test_wr_q, test_wr_d;
  logic [FAULT_W-1:0]          fen_q,     fen_d;
  logic [FAULT_W-1:0]          held_q,    held_d;
  logic [VAL_W-1:0]            res_q      [NUM_CH];
  logic [VAL_W-1:0]            res_d      [NUM_CH];
  logic [NUM_CH-1:0]           fresh_q,   fresh_d;
  logic [VAL_W-1:0]            hi_q       [NUM_LIM];
  logic [VAL_W-1:0]            hi_d       [NUM_LIM];
  logic [VAL_W-1:0]            lo_q       [NUM_LIM];
  logic [VAL_W-1:0]            lo_d       [NUM_LIM];
  logic [NUM_LIM-1:0]          ov_q,      ov_d;
  logic [NUM_LIM-1:0]          uv_q,      uv_d;
  logic                        aligned_q, aligned_d;
  logic                        align_busy_q, align_busy_d;
  logic [CNT_W-1:0]            align_cnt_q,  align_cnt_d;
  logic                        pending_q, pending_d;
  logic                        ramp_q,    ramp_d;
  logic                        rsp_valid_q, rsp_valid_d;
  logic [DATA_W-1:0]           rsp_data_q,  rsp_data_d;
  logic                        ack_tgl_q, ack_tgl_d;
  logic                        req_s1_q, req_s2_q, req_s3_q;

  // ---------------- link clock state ----------------
  logic                        lrst_s1_q, lrst_q;
  logic [NUM_CH-1:0]           lmon_s1_q, lmon_s2_q;
  logic                        ack_s1_q,  ack_s2_q;
  logic [CHAN_W-1:0]           chan_q,    chan_d;
  logic                        run_q,     run_d;
  sample_t                     hold_q,    hold_d;
  logic                        req_tgl_q, req_tgl_d;

  // Next enabled channel after cur, wrapping; cur if none
  function automatic logic [CHAN_W-1:0] next_chan(input logic [CHAN_W-1:0] cur,
                                                  input logic [NUM_CH-1:0] en);
    logic [CHAN_W-1:0] c;
    logic              found;
    c         = cur;
    found     = 1'b0;
    next_chan = cur;
    for (int k = 0; k < NUM_CH; k++)
    begin
      c = (c == CHAN_W'(NUM_CH - 1)) ? '0 : c + 1'b1;
      if (!found && en[c])
      begin
        next_chan = c;
        found     = 1'b1;
      end
    end
  endfunction

  // Link reset: asserted at once, released on the link clock
  always_ff @(posedge adc_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      lrst_s1_q <= 1'b1;
      lrst_q    <= 1'b1;
    end
    else
    begin
      lrst_s1_q <= 1'b0;
      lrst_q    <= lrst_s1_q;
    end
  end

  // Link side synchronisers for enables and acknowledge
  always_ff @(posedge adc_clk_i or posedge lrst_q)
  begin
    if (lrst_q)
    begin
      lmon_s1_q <= MONITOR_RESET;
      lmon_s2_q <= MONITOR_RESET;
      ack_s1_q  <= 1'b0;
      ack_s2_q  <= 1'b0;
    end
    else
    begin
      lmon_s1_q <= mon_q;
      lmon_s2_q <= lmon_s1_q;
      ack_s1_q  <= ack_tgl_q;
      ack_s2_q  <= ack_s1_q;
    end
  end

  // Converter scheduler and sample handoff
  always_comb
  begin
    chan_d    = chan_q;
    hold_d    = hold_q;
    req_tgl_d = req_tgl_q;
    run_d     = |lmon_s2_q;
    if (run_q)
    begin
      if (!lmon_s2_q[chan_q])
        chan_d = next_chan(chan_q, lmon_s2_q);
      else if (sample_valid_i && (req_tgl_q == ack_s2_q))
      begin
        hold_d.chan  = chan_q;
        hold_d.value = sample_value_i;
        req_tgl_d    = ~req_tgl_q;
        chan_d       = next_chan(chan_q, lmon_s2_q);
      end
    end
  end

  always_ff @(posedge adc_clk_i or posedge lrst_q)
  begin
    if (lrst_q)
    begin
      chan_q    <= CH_CORE;
      run_q     <= 1'b0;
      hold_q    <= '0;
      req_tgl_q <= 1'b0;
    end
    else
    begin
      chan_q    <= chan_d;
      run_q     <= run_d;
      hold_q    <= hold_d;
      req_tgl_q <= req_tgl_d;
    end
  end

  assign adc_select_o = chan_q;
  assign adc_run_o    = run_q;

  // System side synchroniser for the sample request toggle
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
    end
    else
    begin
      req_s1_q <= req_tgl_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
    end
  end

  // Register file, faults, tracking and responses
  always_comb
  begin
    logic        wr;
    logic        rd;
    logic        new_sample;
    logic [NUM_LIM-1:0] inst;
    wr          = cmd_valid_i && cmd_i.write;
    rd          = cmd_valid_i && !cmd_i.write;
    new_sample  = req_s2_q ^ req_s3_q;
    inst        = '0;
    mon_d       = mon_q;
    test_wr_d   = test_wr_q;
    fen_d       = fen_q;
    held_d      = held_q;
    res_d       = res_q;
    fresh_d     = fresh_q;
    hi_d        = hi_q;
    lo_d        = lo_q;
    aligned_d   = aligned_q;
    align_busy_d = align_busy_q;
    align_cnt_d = align_cnt_q;
    pending_d   = pending_q;
    ramp_d      = 1'b0;
    ack_tgl_d   = req_s2_q;
    rsp_valid_d = rd;
    rsp_data_d  = '0;

    // Alignment sequence runs down a counter
    if (align_busy_q)
    begin
      if (align_cnt_q == '0)
      begin
        align_busy_d = 1'b0;
        aligned_d    = 1'b1;
      end
      else
        align_cnt_d = align_cnt_q - 1'b1;
    end

    // Tracking ends when the ramp logic reports done
    if (ramp_done_i)
      pending_d = 1'b0;

    // Register writes
    if (wr)
    begin
      case (cmd_i.code)
        CMD_MONITOR_SELECT: mon_d = cmd_i.wdata[NUM_CH-1:0];
        CMD_TRACKING_ALIGNMENT:
        begin
          if (cmd_i.wdata[SYNC_BIT])
          begin
            aligned_d    = 1'b0;
            align_busy_d = 1'b1;
            align_cnt_d  = CNT_W'(ALIGN_CYCLES - 1);
          end
        end
        CMD_TEST_CONTROL:
        begin
          test_wr_d = cmd_i.wdata[TEST_WRITE_BIT];
          if (cmd_i.wdata[BEGIN_RAMP_BIT])
          begin
            pending_d = 1'b1;
            ramp_d    = 1'b1;
            aligned_d = 1'b0;
          end
        end
        CMD_FAULT_ENABLE: fen_d = cmd_i.wdata[FAULT_W-1:0];
        default:
        begin
          for (int i = 0; i < NUM_CH; i++)
            if (test_wr_q && cmd_i.code == CMD_RESULT_BASE + CODE_W'(i))
              res_d[i] = cmd_i.wdata[VAL_W-1:0];
          for (int i = 0; i < NUM_LIM; i++)
          begin
            if (cmd_i.code == CMD_HIGH_BASE + CODE_W'(i))
              hi_d[i] = cmd_i.wdata[VAL_W-1:0];
            if (cmd_i.code == CMD_LOW_BASE + CODE_W'(i))
              lo_d[i] = cmd_i.wdata[VAL_W-1:0];
          end
        end
      endcase
    end

    // Register reads and their side effects
    if (rd)
    begin
      case (cmd_i.code)
        CMD_MONITOR_SELECT: rsp_data_d[NUM_CH-1:0] = mon_q;
        CMD_TRACKING_ALIGNMENT: rsp_data_d[SYNC_BIT] = aligned_q;
        CMD_TEST_CONTROL:
        begin
          rsp_data_d[TEST_WRITE_BIT] = test_wr_q;
          rsp_data_d[BEGIN_RAMP_BIT] = pending_q;
        end
        CMD_FAULT_ENABLE: rsp_data_d[FAULT_W-1:0] = fen_q;
        CMD_HELD_FAULT:
        begin
          rsp_data_d[FAULT_W-1:0] = held_q;
          held_d = '0;
        end
        default:
        begin
          for (int i = 0; i < NUM_CH; i++)
            if (cmd_i.code == CMD_RESULT_BASE + CODE_W'(i))
            begin
              rsp_data_d = {fresh_q[i], res_q[i]};
              fresh_d[i] = 1'b0;
            end
          for (int i = 0; i < NUM_LIM; i++)
          begin
            if (cmd_i.code == CMD_HIGH_BASE + CODE_W'(i))
              rsp_data_d[VAL_W-1:0] = hi_q[i];
            if (cmd_i.code == CMD_LOW_BASE + CODE_W'(i))
              rsp_data_d[VAL_W-1:0] = lo_q[i];
          end
        end
      endcase
    end

    // Converter store; blocked in test mode, set beats read clear
    if (new_sample && !test_wr_q)
    begin
      res_d[hold_q.chan]   = hold_q.value;
      fresh_d[hold_q.chan] = 1'b1;
    end

    // Instantaneous comparisons on stored results
    for (int i = 0; i < NUM_LIM; i++)
    begin
      ov_d[i] = (hi_q[i] != HIGH_DISABLE) && ($signed(res_q[i]) > $signed(hi_q[i]));
      uv_d[i] = (lo_q[i] != LOW_DISABLE) && ($signed(res_q[i]) < $signed(lo_q[i]));
      inst[i] = ov_q[i];
    end

    // Latch enabled faults; disable clears at once, set beats read clear
    held_d = held_d & fen_d;
    held_d = held_d | ({uv_q, inst} & fen_q & fen_d);
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mon_q        <= MONITOR_RESET;
      test_wr_q    <= 1'b0;
      fen_q        <= FAULT_EN_RESET;
      held_q       <= '0;
      fresh_q      <= '0;
      ov_q         <= '0;
      uv_q         <= '0;
      aligned_q    <= 1'b0;
      align_busy_q <= 1'b0;
      align_cnt_q  <= '0;
      pending_q    <= 1'b0;
      ramp_q       <= 1'b0;
      rsp_valid_q  <= 1'b0;
      rsp_data_q   <= '0;
      ack_tgl_q    <= 1'b0;
      for (int i = 0; i < NUM_CH; i++)
        res_q[i] <= RESULT_RESET;
      for (int i = 0; i < NUM_LIM; i++)
      begin
        hi_q[i] <= HIGH_DISABLE;
        lo_q[i] <= LOW_DISABLE;
      end
    end
    else
    begin
      mon_q        <= mon_d;
      test_wr_q    <= test_wr_d;
      fen_q        <= fen_d;
      held_q       <= held_d;
      res_q        <= res_d;
      fresh_q      <= fresh_d;
      hi_q         <= hi_d;
      lo_q         <= lo_d;
      ov_q         <= ov_d;
      uv_q         <= uv_d;
      aligned_q    <= aligned_d;
      align_busy_q <= align_busy_d;
      align_cnt_q  <= align_cnt_d;
      pending_q    <= pending_d;
      ramp_q       <= ramp_d;
      rsp_valid_q  <= rsp_valid_d;
      rsp_data_q   <= rsp_data_d;
      ack_tgl_q    <= ack_tgl_d;
    end
  end

  // Outputs straight from flops
  assign rsp_valid_o  = rsp_valid_q;
  assign rsp_data_o   = rsp_data_q;
  assign ramp_start_o = ramp_q;
  assign ov_fault_o   = ov_q;
  assign uv_fault_o   = uv_q;
  assign held_fault_o = held_q;

endmodule // adc_monitor_limit_regs

/* File: testbench/adc_monitor_checker.sv */
`timescale 1ns/1ns
module adc_monitor_checker
  import adc_monitor_pkg::*;
#(
  parameter int ALIGN_CYCLES = ALIGN_CYCLES_DEFAULT
)(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               cmd_valid_i,
  input  wire cmd_t               cmd_i,
  input  wire logic               rsp_valid_o,
  input  wire logic [DATA_W-1:0]  rsp_data_o,
  input  wire logic               ramp_start_o,
  input  wire logic [NUM_LIM-1:0] ov_fault_o,
  input  wire logic [NUM_LIM-1:0] uv_fault_o,
  input  wire logic [FAULT_W-1:0] held_fault_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Command port answers
  a_read_answer: assert property (cmd_valid_i && !cmd_i.write |=> rsp_valid_o)
    else $error("read got no answer");
  a_write_silent: assert property (cmd_valid_i && cmd_i.write |=> !rsp_valid_o)
    else $error("write gave an answer");
  // Reserved bits read zero
  a_monitor_upper: assert property (rsp_valid_o && $past(cmd_i.code) == CMD_MONITOR_SELECT |-> rsp_data_o[15:7] == 9'h000)
    else $error("monitor select upper bits set");
  a_align_upper: assert property (rsp_valid_o && $past(cmd_i.code) == CMD_TRACKING_ALIGNMENT |-> rsp_data_o[15:1] == 15'h0000)
    else $error("alignment upper bits set");
  a_limit_bit15: assert property (rsp_valid_o && $past(cmd_i.code) >= CMD_HIGH_BASE &&
    $past(cmd_i.code) <= 8'h2D |-> !rsp_data_o[15])
    else $error("limit bit 15 set");
  // Ramp start pulse and its cause
  a_ramp_pulse: assert property (cmd_valid_i && cmd_i.write && cmd_i.code == CMD_TEST_CONTROL &&
    cmd_i.wdata[BEGIN_RAMP_BIT] |=> ramp_start_o)
    else $error("ramp start missing");
  a_ramp_cause: assert property (ramp_start_o |-> $past(cmd_valid_i && cmd_i.write && cmd_i.code == CMD_TEST_CONTROL))
    else $error("ramp start without command");
  // Held bits only rise from a live fault
  a_held_cause: assert property ((held_fault_o & ~$past(held_fault_o) & ~$past({uv_fault_o, ov_fault_o})) == '0)
    else $error("held bit set without fault");
endmodule // adc_monitor_checker

bind adc_monitor_limit_regs adc_monitor_checker #(.ALIGN_CYCLES(ALIGN_CYCLES)) u_adc_monitor_checker (
  .clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .rsp_valid_o(rsp_valid_o),
  .rsp_data_o(rsp_data_o), .ramp_start_o(ramp_start_o), .ov_fault_o(ov_fault_o), .uv_fault_o(uv_fault_o),
  .held_fault_o(held_fault_o));

/* File: testbench/adc_converter_model.sv */
`timescale 1ns/1ns
module adc_converter_model
  import adc_monitor_pkg::*;
(
  input  wire logic                         adc_clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         run_i,
  input  wire logic [CHAN_W-1:0]            select_i,
  input  wire logic [NUM_CH-1:0][VAL_W-1:0] levels_i,
  output logic                              sample_valid_o,
  output logic [VAL_W-1:0]                  sample_value_o
);
  logic [2:0] gap_q;

  // One conversion each six link cycles; data line scrambles between
  always @(negedge adc_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      gap_q <= 3'h0;
      sample_valid_o <= 1'b0;
      sample_value_o <= 15'h0000;
    end
    else
    begin
      sample_valid_o <= 1'b0;
      sample_value_o <= ~sample_value_o;
      if (run_i)
      begin
        gap_q <= (gap_q == 3'h5) ? 3'h0 : gap_q + 3'h1;
        if (gap_q == 3'h5)
        begin
          sample_valid_o <= 1'b1;
          sample_value_o <= levels_i[select_i];
        end
      end
    end
  end
endmodule // adc_converter_model

/* File: testbench/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  import adc_monitor_pkg::*;
  localparam int ALIGN = 4;
  localparam logic [NUM_CH-1:0][VAL_W-1:0] LEVELS = {15'h4000, 15'h3FFF, 15'h0600, 15'h0500, 15'h0400, 15'h0300,
    15'h0201};
  // Result, high limit, low limit, expected over and under
  localparam logic [46:0] CASES [5] = '{{15'h3FFF, 15'h3FFE, 15'h4000, 2'b10}, {15'h3FFF, 15'h3FFF, 15'h4000, 2'b00},
    {15'h4000, 15'h0000, 15'h4001, 2'b01}, {15'h4000, 15'h3FFF, 15'h4000, 2'b00}, {15'h0000, 15'h7FFF, 15'h0001, 2'b11}};
  logic               clk_i = 1'b1;
  logic               adc_clk_i;
  logic               rst_i;
  logic               cmd_valid_i;
  cmd_t               cmd_i;
  logic               rsp_valid_o;
  logic [DATA_W-1:0]  rsp_data_o;
  logic               ramp_done_i;
  logic               ramp_start_o;
  logic [NUM_LIM-1:0] ov_fault_o;
  logic [NUM_LIM-1:0] uv_fault_o;
  logic [FAULT_W-1:0] held_fault_o;
  logic               sample_valid_i;
  logic [VAL_W-1:0]   sample_value_i;
  logic [CHAN_W-1:0]  adc_select_o;
  logic               adc_run_o;
  logic [DATA_W-1:0]  rd;
  int                 fails;
  int                 n_checks;
  int                 cycles;

  // Clocks; link clock offset in phase
  always #4 clk_i = ~clk_i;
  initial
  begin
    adc_clk_i = 1'b0;
    #13;
    forever #80 adc_clk_i = ~adc_clk_i;
  end

  adc_monitor_limit_regs #(.ALIGN_CYCLES(ALIGN)) u_adc_monitor_limit_regs (
    .clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .rsp_valid_o(rsp_valid_o),
    .rsp_data_o(rsp_data_o), .ramp_done_i(ramp_done_i), .ramp_start_o(ramp_start_o), .ov_fault_o(ov_fault_o),
    .uv_fault_o(uv_fault_o), .held_fault_o(held_fault_o), .adc_clk_i(adc_clk_i), .sample_valid_i(sample_valid_i),
    .sample_value_i(sample_value_i), .adc_select_o(adc_select_o), .adc_run_o(adc_run_o));

  adc_converter_model u_adc_converter_model (
    .adc_clk_i(adc_clk_i), .rst_i(rst_i), .run_i(adc_run_o), .select_i(adc_select_o), .levels_i(LEVELS),
    .sample_valid_o(sample_valid_i), .sample_value_o(sample_value_i));

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One command; read data taken while the answer stands
  task automatic access(input logic wr, input logic [7:0] code, input logic [15:0] data);
    @(negedge clk_i);
    cmd_valid_i = 1'b1;
    cmd_i = '{write: wr, code: code, wdata: data};
    @(negedge clk_i);
    cmd_valid_i = 1'b0;
    rd = (rsp_valid_o === 1'b1) ? rsp_data_o : 16'hDEAD;
  endtask

  task automatic rdchk(input logic [7:0] code, input logic [15:0] exp);
    access(1'b0, code, 16'h0000);
    chk(rd, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // Hang guard
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      report_and_stop();
    end
  end

  // Main sequence; reset rises on the first falling edge, before any rising one
  initial
  begin
    rst_i = 1'b0;
    cmd_valid_i = 1'b0;
    cmd_i = '0;
    ramp_done_i = 1'b0;
    @(negedge clk_i);
    rst_i = 1'b1;
    repeat (16) @(negedge clk_i);
    rst_i = 1'b0;
    rdchk(CMD_MONITOR_SELECT, 16'h0000);
    rdchk(CMD_TRACKING_ALIGNMENT, 16'h0000);
    access(1'b1, CMD_HIGH_BASE, 16'hFFFF);
    rdchk(CMD_HIGH_BASE, 16'h7FFF);
    access(1'b1, CMD_RESULT_BASE, 16'h1234);
    rdchk(CMD_RESULT_BASE, 16'h0000);
    access(1'b1, CMD_TRACKING_ALIGNMENT, 16'hFFFF);
    idle(ALIGN + 4);
    rdchk(CMD_TRACKING_ALIGNMENT, 16'h0001);
    access(1'b1, CMD_TEST_CONTROL, 16'h0002);
    chk({15'h0000, ramp_start_o}, 16'h0001);
    rdchk(CMD_TEST_CONTROL, 16'h0002);
    ramp_done_i = 1'b1;
    idle(1);
    ramp_done_i = 1'b0;
    rdchk(CMD_TEST_CONTROL, 16'h0000);
    rdchk(CMD_TRACKING_ALIGNMENT, 16'h0000);
    // Converter visits every enabled input
    access(1'b1, CMD_MONITOR_SELECT, 16'hFFFF);
    rdchk(CMD_MONITOR_SELECT, 16'h007F);
    idle(1500);
    chk({15'h0000, adc_run_o}, 16'h0001);
    for (int i = 0; i < NUM_CH; i++)
      rdchk(CMD_RESULT_BASE + 8'(i), {1'b1, LEVELS[i]});
    // Disabled inputs skipped; fresh flags cleared once the enables settle
    access(1'b1, CMD_MONITOR_SELECT, 16'h0024);
    idle(150);
    for (int i = 0; i < NUM_CH; i++)
      access(1'b0, CMD_RESULT_BASE + 8'(i), 16'h0000);
    idle(1000);
    chk({15'h0000, (adc_select_o == CH_C0_PRI) || (adc_select_o == CH_C1_SEC)}, 16'h0001);
    for (int i = 0; i < NUM_CH; i++)
      rdchk(CMD_RESULT_BASE + 8'(i), {(i == CH_C0_PRI) || (i == CH_C1_SEC), LEVELS[i]});
    access(1'b1, CMD_MONITOR_SELECT, 16'h0000);
    idle(200);
    access(1'b0, CMD_RESULT_BASE + 8'h02, 16'h0000);
    idle(400);
    chk({15'h0000, adc_run_o}, 16'h0000);
    rdchk(CMD_RESULT_BASE + 8'h02, {1'b0, LEVELS[2]});
    // Host-owned results against limits, converter blocked
    access(1'b1, CMD_TEST_CONTROL, 16'h0001);
    access(1'b1, CMD_MONITOR_SELECT, 16'h0001);
    foreach (CASES[k])
    begin
      access(1'b1, CMD_RESULT_BASE, {1'b0, CASES[k][46:32]});
      access(1'b1, CMD_HIGH_BASE, {1'b0, CASES[k][31:17]});
      access(1'b1, CMD_LOW_BASE, {1'b0, CASES[k][16:2]});
      idle(6);
      chk({14'h0000, ov_fault_o[0], uv_fault_o[0]}, {14'h0000, CASES[k][1:0]});
    end
    // Last limited channel uses its own registers
    access(1'b1, CMD_RESULT_BASE + 8'h05, 16'h0000);
    access(1'b1, CMD_HIGH_BASE + 8'h05, 16'h7FFF);
    access(1'b1, CMD_LOW_BASE + 8'h05, 16'h0001);
    idle(6);
    chk({14'h0000, ov_fault_o[5], uv_fault_o[5]}, 16'h0003);
    idle(300);
    rdchk(CMD_RESULT_BASE, 16'h0000);
    access(1'b1, CMD_FAULT_ENABLE, 16'h0001);
    idle(6);
    chk({4'h0, held_fault_o}, 16'h0001);
    access(1'b1, CMD_FAULT_ENABLE, 16'h0000);
    idle(3);
    chk({4'h0, held_fault_o}, 16'h0000);
    // Held bit survives a read while the fault lasts, then reads clear
    access(1'b1, CMD_FAULT_ENABLE, 16'h0001);
    idle(6);
    rdchk(CMD_HELD_FAULT, 16'h0001);
    access(1'b1, CMD_HIGH_BASE, {1'b0, HIGH_DISABLE});
    idle(4);
    rdchk(CMD_HELD_FAULT, 16'h0001);
    rdchk(CMD_HELD_FAULT, 16'h0000);
    report_and_stop();
  end
endmodule // tb_top
